// ===== hw/scp_map.vh
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
`define SCP_ADDR_W 15
`define SCP_DATA_W 8
`define SCP_HDR_BITS 5'd16
`define SCP_DIR_READ 1'b1
`define SCP_DIR_WRITE 1'b0
`define SCP_SYNC_REG_ADDR 15'h0015
`define SCP_SYNC_BIT 6
`define SCP_CLK_MHZ 125
`define SCP_PD_MIN_NS 200
`define SCP_PD_MIN_CYC ((`SCP_PD_MIN_NS * `SCP_CLK_MHZ + 999) / 1000)
`define SCP_STRAP_I2C 1'b0
`define SCP_SYNC_W 9
`endif

// ===== hw/scp_sync2.v
`timescale 1ns/100ps
`default_nettype none
module scp_sync2 #(
  parameter WIDTH = 1
) (
  input wire core_clk_in, // core clock
  input wire sys_rst_in, // async reset, high
  input wire [WIDTH-1:0] async_in, // pin levels
  output reg [WIDTH-1:0] sync_out // synchronised levels
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ===== hw/scp_serial_config_port.v
`timescale 1ns/100ps
`default_nettype none
`include "scp_map.vh"
// Notes on behaviour
// - three_wire_disable low: data on shared pin
// - three_wire_disable high: readback on chosen gpio
// - spi mode: select pin also triggers counter
// - readback driver may be open drain
// - direction 0 writes, 1 reads
// - frame spans select low; dir first
// - write committed on last data bit
// - incomplete trailing bits are dropped
// - read bits change on falling clock
// - address increments per byte after header
// - i2c block reads and writes auto-increment
// - sync bit holds dividers, clear releases
// - power-down low disables the interface
// - power-down rising starts power-on sequence
// - straps latched at start-up
// - strap low selects i2c target
// - i2c address lsbs from select pin
// - same register map on both interfaces
module scp_serial_config_port (
  input wire core_clk_in, // 125 MHz core clock
  input wire sys_rst_in, // async reset, high
  input wire power_down_n_in, // power-down pin, low active
  input wire sck_in, // spi clock or i2c clock pin
  input wire select_or_addr_strap_pin_in, // spi select_n or i2c address pin
  input wire [1:0] addr_strap_level_in, // decoded address pin level
  input wire sdio_in, // data pin level
  input wire iface_strap_in, // interface strap pin
  input wire [1:0] rom_page_strap_in, // rom page strap pins
  input wire [4:0] nvm_addr_msb_in, // upper i2c address bits
  input wire three_wire_disable_in, // 1 selects 4-wire spi
  input wire [1:0] sdo_gpio_sel_in, // gpio used as readback
  input wire sdo_open_drain_in, // open-drain readback
  input wire [7:0] reg_rdata_in, // register read data
  output reg sdio_out, // data pin drive value
  output reg sdio_oe_out, // data pin enable
  output reg [3:0] gpio_sdo_out, // gpio readback values
  output reg [3:0] gpio_sdo_oe_out, // gpio readback enables
  output reg [14:0] reg_addr_out, // register address
  output reg [7:0] reg_wdata_out, // register write data
  output reg reg_wr_out, // write strobe pulse
  output reg reg_rd_out, // read strobe pulse
  output reg sync_hold_out, // holds output dividers
  output reg elapsed_time_counter_trig_out, // counter trigger pulse
  output reg por_start_out, // power-on sequence start pulse
  output reg device_down_out, // device powered down
  output reg i2c_mode_out, // latched interface mode
  output reg [1:0] rom_page_out, // latched rom page
  output reg [6:0] i2c_dev_addr_out // latched i2c address
);
  localparam I_IDLE = 3'd0;
  localparam I_ADDR = 3'd1;
  localparam I_ACK = 3'd2;
  localparam I_WR = 3'd3;
  localparam I_RD = 3'd4;
  localparam I_RACK = 3'd5;

  function [14:0] addr_inc;
    input [14:0] a;
    begin
      addr_inc = a + 15'h0001;
    end
  endfunction

  wire [8:0] sync_w;
  scp_sync2 #(.WIDTH(`SCP_SYNC_W)) u_sync (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in({power_down_n_in, sck_in, select_or_addr_strap_pin_in, sdio_in, iface_strap_in,
      rom_page_strap_in, addr_strap_level_in}),
    .sync_out(sync_w)
  );
  wire pd_n_s = sync_w[8];
  wire sck_s = sync_w[7];
  wire sel_s = sync_w[6];
  wire sda_s = sync_w[5];

  reg sck_d_reg, sel_d_reg, sda_d_reg;
  reg [7:0] pd_cnt_reg;
  reg [1:0] rd_pipe_reg;
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sck_d_reg <= 1'b1;
      sel_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      sel_d_reg <= sel_s;
      sda_d_reg <= sda_s;
    end
  end
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg;
  wire i2c_start = sck_s & sck_d_reg & sda_d_reg & ~sda_s;
  wire i2c_stop = sck_s & sck_d_reg & ~sda_d_reg & sda_s;
  wire rdata_ok = rd_pipe_reg[1];

  // power-down filter, power-on start and straps
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pd_cnt_reg <= 8'h00;
      device_down_out <= 1'b1;
      por_start_out <= 1'b0;
      i2c_mode_out <= 1'b0;
      rom_page_out <= 2'h0;
      i2c_dev_addr_out <= 7'h00;
    end else begin
      por_start_out <= 1'b0;
      if (pd_n_s) begin
        pd_cnt_reg <= 8'h00;
        if (device_down_out) begin
          device_down_out <= 1'b0;
          por_start_out <= 1'b1;
          i2c_mode_out <= (sync_w[4] == `SCP_STRAP_I2C);
          rom_page_out <= sync_w[3:2];
          i2c_dev_addr_out <= {nvm_addr_msb_in, sync_w[1:0]};
        end
      end else if (!device_down_out) begin
        if (pd_cnt_reg == `SCP_PD_MIN_CYC - 1)
          device_down_out <= 1'b1;
        else
          pd_cnt_reg <= pd_cnt_reg + 8'h01;
      end
    end
  end

  wire spi_on = ~device_down_out & ~i2c_mode_out;
  wire i2c_on = ~device_down_out & i2c_mode_out;

  // spi engine
  reg [4:0] hdr_cnt_reg;
  reg [2:0] dbit_reg;
  reg dir_reg;
  reg [14:0] spi_addr_reg, spi_req_addr_reg;
  reg [7:0] spi_shift_reg, spi_tx_reg, spi_wdata_reg;
  reg spi_wr_reg, spi_rd_reg, sdo_bit_reg;
  wire spi_frame = spi_on & ~sel_s;
  wire spi_data = spi_frame & (hdr_cnt_reg == `SCP_HDR_BITS);
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hdr_cnt_reg <= 5'd0;
      dbit_reg <= 3'd0;
      dir_reg <= 1'b0;
      spi_addr_reg <= 15'h0000;
      spi_req_addr_reg <= 15'h0000;
      spi_shift_reg <= 8'h00;
      spi_tx_reg <= 8'h00;
      spi_wdata_reg <= 8'h00;
      spi_wr_reg <= 1'b0;
      spi_rd_reg <= 1'b0;
      sdo_bit_reg <= 1'b1;
    end else begin
      spi_wr_reg <= 1'b0;
      spi_rd_reg <= 1'b0;
      if (rdata_ok)
        spi_tx_reg <= reg_rdata_in;
      if (!spi_frame) begin
        hdr_cnt_reg <= 5'd0;
        dbit_reg <= 3'd0;
      end else if (sck_rise) begin
        if (hdr_cnt_reg != `SCP_HDR_BITS) begin
          hdr_cnt_reg <= hdr_cnt_reg + 5'd1;
          if (hdr_cnt_reg == 5'd0)
            dir_reg <= sda_s;
          else
            spi_addr_reg <= {spi_addr_reg[13:0], sda_s};
          if (hdr_cnt_reg == `SCP_HDR_BITS - 5'd1 && dir_reg == `SCP_DIR_READ) begin
            spi_rd_reg <= 1'b1;
            spi_req_addr_reg <= {spi_addr_reg[13:0], sda_s};
          end
        end else begin
          spi_shift_reg <= {spi_shift_reg[6:0], sda_s};
          dbit_reg <= dbit_reg + 3'd1;
          if (dbit_reg == 3'd7) begin
            spi_addr_reg <= addr_inc(spi_addr_reg);
            if (dir_reg == `SCP_DIR_WRITE) begin
              spi_wr_reg <= 1'b1;
              spi_wdata_reg <= {spi_shift_reg[6:0], sda_s};
              spi_req_addr_reg <= spi_addr_reg;
            end else begin
              spi_rd_reg <= 1'b1;
              spi_req_addr_reg <= addr_inc(spi_addr_reg);
            end
          end
        end
      end else if (sck_fall && spi_data && dir_reg == `SCP_DIR_READ) begin
        sdo_bit_reg <= spi_tx_reg[7];
        spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
      end
      if (!spi_data)
        sdo_bit_reg <= 1'b1;
    end
  end

  // i2c target engine
  reg [2:0] i_state_reg;
  reg [3:0] ibit_reg;
  reg [1:0] ibyte_reg;
  reg [7:0] ishift_reg, itx_reg, i_wdata_reg;
  reg irw_reg, sda_low_reg, i_wr_reg, i_rd_reg;
  reg [14:0] i_addr_reg, i_req_addr_reg;
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      i_state_reg <= I_IDLE;
      ibit_reg <= 4'd0;
      ibyte_reg <= 2'd0;
      ishift_reg <= 8'h00;
      itx_reg <= 8'h00;
      i_wdata_reg <= 8'h00;
      irw_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      i_wr_reg <= 1'b0;
      i_rd_reg <= 1'b0;
      i_addr_reg <= 15'h0000;
      i_req_addr_reg <= 15'h0000;
    end else begin
      i_wr_reg <= 1'b0;
      i_rd_reg <= 1'b0;
      if (rdata_ok)
        itx_reg <= reg_rdata_in;
      if (!i2c_on || i2c_stop) begin
        i_state_reg <= I_IDLE;
        sda_low_reg <= 1'b0;
      end else if (i2c_start) begin
        i_state_reg <= I_ADDR;
        ibit_reg <= 4'd0;
        ibyte_reg <= 2'd0;
        sda_low_reg <= 1'b0;
      end else begin
        case (i_state_reg)
          I_ADDR, I_WR: begin
            if (sck_rise && ibit_reg != 4'd8) begin
              ishift_reg <= {ishift_reg[6:0], sda_s};
              ibit_reg <= ibit_reg + 4'd1;
            end else if (sck_fall && ibit_reg == 4'd8) begin
              ibit_reg <= 4'd0;
              if (i_state_reg == I_ADDR) begin
                if (ishift_reg[7:1] == i2c_dev_addr_out) begin
                  sda_low_reg <= 1'b1;
                  irw_reg <= ishift_reg[0];
                  i_state_reg <= I_ACK;
                  if (ishift_reg[0]) begin
                    i_rd_reg <= 1'b1;
                    i_req_addr_reg <= i_addr_reg;
                  end
                end else
                  i_state_reg <= I_IDLE;
              end else begin
                sda_low_reg <= 1'b1;
                i_state_reg <= I_ACK;
                if (ibyte_reg == 2'd0) begin
                  i_addr_reg[14:8] <= ishift_reg[6:0];
                  ibyte_reg <= 2'd1;
                end else if (ibyte_reg == 2'd1) begin
                  i_addr_reg[7:0] <= ishift_reg;
                  ibyte_reg <= 2'd2;
                end else begin
                  i_wr_reg <= 1'b1;
                  i_wdata_reg <= ishift_reg;
                  i_req_addr_reg <= i_addr_reg;
                  i_addr_reg <= addr_inc(i_addr_reg);
                end
              end
            end
          end
          I_ACK: begin
            if (sck_fall) begin
              if (irw_reg) begin
                sda_low_reg <= ~itx_reg[7];
                itx_reg <= {itx_reg[6:0], 1'b0};
                i_state_reg <= I_RD;
              end else begin
                sda_low_reg <= 1'b0;
                i_state_reg <= I_WR;
              end
            end
          end
          I_RD: begin
            if (sck_fall) begin
              ibit_reg <= ibit_reg + 4'd1;
              if (ibit_reg == 4'd7) begin
                sda_low_reg <= 1'b0;
                ibit_reg <= 4'd0;
                i_state_reg <= I_RACK;
                i_addr_reg <= addr_inc(i_addr_reg);
                i_rd_reg <= 1'b1;
                i_req_addr_reg <= addr_inc(i_addr_reg);
              end else begin
                sda_low_reg <= ~itx_reg[7];
                itx_reg <= {itx_reg[6:0], 1'b0};
              end
            end
          end
          I_RACK: begin
            if (sck_rise && sda_s)
              i_state_reg <= I_IDLE;
            else if (sck_fall) begin
              sda_low_reg <= ~itx_reg[7];
              itx_reg <= {itx_reg[6:0], 1'b0};
              i_state_reg <= I_RD;
            end
          end
          default: i_state_reg <= I_IDLE;
        endcase
      end
    end
  end

  // register port, sync control, pins
  wire spi_drive = spi_data & (dir_reg == `SCP_DIR_READ);
  wire od_val = sdo_open_drain_in ? 1'b0 : sdo_bit_reg;
  wire od_oe = ~sdo_open_drain_in | ~sdo_bit_reg;
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_addr_out <= 15'h0000;
      reg_wdata_out <= 8'h00;
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      rd_pipe_reg <= 2'b00;
      sync_hold_out <= 1'b0;
      elapsed_time_counter_trig_out <= 1'b0;
      sdio_out <= 1'b0;
      sdio_oe_out <= 1'b0;
      gpio_sdo_out <= 4'h0;
      gpio_sdo_oe_out <= 4'h0;
    end else begin
      reg_wr_out <= spi_wr_reg | i_wr_reg;
      reg_rd_out <= spi_rd_reg | i_rd_reg;
      rd_pipe_reg <= {rd_pipe_reg[0], spi_rd_reg | i_rd_reg};
      if (spi_wr_reg | spi_rd_reg)
        reg_addr_out <= spi_req_addr_reg;
      else if (i_wr_reg | i_rd_reg)
        reg_addr_out <= i_req_addr_reg;
      if (spi_wr_reg)
        reg_wdata_out <= spi_wdata_reg;
      else if (i_wr_reg)
        reg_wdata_out <= i_wdata_reg;
      if (spi_wr_reg && spi_req_addr_reg == `SCP_SYNC_REG_ADDR)
        sync_hold_out <= spi_wdata_reg[`SCP_SYNC_BIT];
      else if (i_wr_reg && i_req_addr_reg == `SCP_SYNC_REG_ADDR)
        sync_hold_out <= i_wdata_reg[`SCP_SYNC_BIT];
      elapsed_time_counter_trig_out <= spi_on & sel_s & ~sel_d_reg;
      gpio_sdo_out <= 4'h0;
      gpio_sdo_oe_out <= 4'h0;
      if (i2c_on) begin
        sdio_out <= 1'b0;
        sdio_oe_out <= sda_low_reg;
      end else if (spi_drive && !three_wire_disable_in) begin
        sdio_out <= od_val;
        sdio_oe_out <= od_oe;
      end else begin
        sdio_out <= 1'b0;
        sdio_oe_out <= 1'b0;
        if (spi_drive) begin
          gpio_sdo_out[sdo_gpio_sel_in] <= od_val;
          gpio_sdo_oe_out[sdo_gpio_sel_in] <= od_oe;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/scp_serial_config_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "scp_map.vh"
module scp_serial_config_port_properties (
  input wire logic core_clk_in, // core clock
  input wire logic sys_rst_in, // async reset
  input wire logic power_down_n_in, // power-down pin
  input wire logic select_or_addr_strap_pin_in, // select pin
  input wire logic three_wire_disable_in, // 4-wire mode
  input wire logic sdo_open_drain_in, // open-drain readback
  input wire logic sdio_oe_out, // data pin enable
  input wire logic [3:0] gpio_sdo_out, // gpio readback
  input wire logic [3:0] gpio_sdo_oe_out, // gpio enables
  input wire logic [14:0] reg_addr_out, // address
  input wire logic [7:0] reg_wdata_out, // write data
  input wire logic reg_wr_out, // write strobe
  input wire logic reg_rd_out, // read strobe
  input wire logic sync_hold_out, // divider hold
  input wire logic elapsed_time_counter_trig_out, // trigger
  input wire logic por_start_out, // power-on start
  input wire logic device_down_out, // powered down
  input wire logic i2c_mode_out, // latched mode
  input wire logic [1:0] rom_page_out // latched page
);
  logic [7:0] pd_low_reg;
  // raw cycles the pin has been low
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      pd_low_reg <= 8'h00;
    else if (power_down_n_in)
      pd_low_reg <= 8'h00;
    else if (pd_low_reg != 8'hff)
      pd_low_reg <= pd_low_reg + 8'h01;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_wr_pulse; reg_wr_out |=> !reg_wr_out; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_rd_pulse; reg_rd_out |=> !reg_rd_out; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_down_quiet; device_down_out |-> !reg_wr_out && !reg_rd_out; endproperty
  a_down_quiet: assert property (p_down_quiet) else $error("strobe while down");
  property p_pd_filter; $rose(device_down_out) |-> pd_low_reg >= 8'h19; endproperty
  a_pd_filter: assert property (p_pd_filter) else $error("short pulse took effect");
  property p_por; $rose(power_down_n_in) && device_down_out |-> ##[2:6] por_start_out; endproperty
  a_por: assert property (p_por) else $error("no power-on start");
  property p_trig;
    $rose(select_or_addr_strap_pin_in) && !i2c_mode_out && !device_down_out |-> ##[1:6] elapsed_time_counter_trig_out;
  endproperty
  a_trig: assert property (p_trig) else $error("no counter trigger");
  property p_sync;
    reg_wr_out && reg_addr_out == `SCP_SYNC_REG_ADDR |-> ##[0:2] sync_hold_out == reg_wdata_out[`SCP_SYNC_BIT];
  endproperty
  a_sync: assert property (p_sync) else $error("sync hold not updated");
  property p_wire4; three_wire_disable_in && !i2c_mode_out |-> !sdio_oe_out; endproperty
  a_wire4: assert property (p_wire4) else $error("data pin driven in 4-wire mode");
  property p_open_drain; sdo_open_drain_in |-> (gpio_sdo_out & gpio_sdo_oe_out) == 4'h0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");
  property p_straps; $changed(rom_page_out) |-> por_start_out || $past(por_start_out); endproperty
  a_straps: assert property (p_straps) else $error("page changed outside start-up");
endmodule
bind scp_serial_config_port scp_serial_config_port_properties u_props (
  .core_clk_in, .sys_rst_in, .power_down_n_in, .select_or_addr_strap_pin_in, .three_wire_disable_in,
  .sdo_open_drain_in, .sdio_oe_out, .gpio_sdo_out, .gpio_sdo_oe_out, .reg_addr_out, .reg_wdata_out,
  .reg_wr_out, .reg_rd_out, .sync_hold_out, .elapsed_time_counter_trig_out, .por_start_out,
  .device_down_out, .i2c_mode_out, .rom_page_out);
`default_nettype wire

// ===== tb/scp_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module scp_spi_host (
  input wire logic core_clk_in, // core clock
  input wire logic miso_in, // readback pin level
  output logic sck_out, // serial clock, idle low
  output logic sel_n_out, // chip select, low active
  output logic mosi_out // data pin drive
);
  initial begin
    sck_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic half;
    repeat (6) @(posedge core_clk_in);
    #1;
  endtask
  // released pin toggles so stale data never reads as valid
  task automatic frame(input logic [47:0] bits, input int n, output logic [47:0] got);
    got = 48'h0;
    @(posedge core_clk_in);
    #1 sel_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      half();
      sck_out = 1'b0;
      mosi_out = (bits[47] && i > 15) ? ~mosi_out : bits[47 - i];
      half();
      got = {got[46:0], miso_in};
      sck_out = 1'b1;
    end
    half();
    sck_out = 1'b0;
    half();
    sel_n_out = 1'b1;
    half();
  endtask
  // i2c start (stop low) or stop on the same pins; sda 1 means released
  task automatic i2c_edge(input logic stop);
    mosi_out = ~stop;
    half();
    sck_out = 1'b1;
    half();
    mosi_out = stop;
    half();
    if (!stop)
      sck_out = 1'b0;
  endtask
  // nine scl clocks: eight bits and the acknowledge slot, sda 1 releases
  task automatic i2c_byte(input logic [8:0] b, output logic [8:0] got);
    got = 9'h0;
    for (int i = 0; i < 9; i++) begin
      mosi_out = b[8 - i];
      half();
      sck_out = 1'b1;
      half();
      got = {got[7:0], miso_in};
      sck_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/scp_serial_config_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module scp_serial_config_port_tb_top;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic power_down_n_in = 1'b1;
  logic iface_strap_in = 1'b1;
  logic three_wire_disable_in = 1'b0;
  logic sdo_open_drain_in = 1'b0;
  logic [1:0] rom_page_strap_in = 2'h2;
  logic [1:0] addr_strap_level_in = 2'h1;
  logic [1:0] sdo_gpio_sel_in = 2'h2;
  logic [4:0] nvm_addr_msb_in = 5'h0c;
  logic [7:0] reg_rdata_in = 8'h00;
  wire sck_in, select_or_addr_strap_pin_in, sdio_in, mosi, miso;
  wire sdio_out, sdio_oe_out, reg_wr_out, reg_rd_out, sync_hold_out, elapsed_time_counter_trig_out;
  wire por_start_out, device_down_out, i2c_mode_out;
  wire [3:0] gpio_sdo_out, gpio_sdo_oe_out;
  wire [14:0] reg_addr_out;
  wire [7:0] reg_wdata_out;
  wire [1:0] rom_page_out;
  wire [6:0] i2c_dev_addr_out;
  logic [22:0] wq[$];
  logic [22:0] exp_w [3] = '{{15'h0014, 8'ha5}, {15'h0015, 8'h40}, {15'h0016, 8'h3c}};
  logic [47:0] got;
  logic [8:0] ack;
  logic [7:0] i2c_w [8] = '{8'h62, 8'h00, 8'h30, 8'h11, 8'h22, 8'h62, 8'h00, 8'h40};
  int n_mismatch = 0;
  int n_checks = 0;
  int n_por = 0;
  int n_trig = 0;
  assign sdio_in = sdio_oe_out ? sdio_out : mosi;
  // gpio readback line has a pull-up
  assign miso = three_wire_disable_in ?
    (gpio_sdo_oe_out[sdo_gpio_sel_in] ? gpio_sdo_out[sdo_gpio_sel_in] : 1'b1) : sdio_in;
  initial begin
    forever #4 core_clk_in = ~core_clk_in;
  end
  scp_serial_config_port dut (
    .core_clk_in, .sys_rst_in, .power_down_n_in, .sck_in, .select_or_addr_strap_pin_in, .addr_strap_level_in,
    .sdio_in, .iface_strap_in, .rom_page_strap_in, .nvm_addr_msb_in, .three_wire_disable_in, .sdo_gpio_sel_in,
    .sdo_open_drain_in, .reg_rdata_in, .sdio_out, .sdio_oe_out, .gpio_sdo_out, .gpio_sdo_oe_out, .reg_addr_out,
    .reg_wdata_out, .reg_wr_out, .reg_rd_out, .sync_hold_out, .elapsed_time_counter_trig_out, .por_start_out,
    .device_down_out, .i2c_mode_out, .rom_page_out, .i2c_dev_addr_out);
  scp_spi_host host (.core_clk_in, .miso_in(miso), .sck_out(sck_in),
    .sel_n_out(select_or_addr_strap_pin_in), .mosi_out(mosi));
  // register file stand-in and event counters
  always @(posedge core_clk_in) begin
    if (reg_rd_out)
      reg_rdata_in <= reg_addr_out[7:0] ^ 8'h5a;
    if (reg_wr_out)
      wq.push_back({reg_addr_out, reg_wdata_out});
    if (por_start_out)
      n_por++;
    if (elapsed_time_counter_trig_out)
      n_trig++;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  initial begin
    #500000;
    n_mismatch++;
    close_out();
  end
  initial begin
    wait_cyc(20);
    sys_rst_in = 1'b0;
    wait_cyc(20);
    check("por", n_por, 1);
    check("straps", {i2c_mode_out, rom_page_out, device_down_out}, 4'h4);
    // block write from lowest address, five stray bits at the end
    host.frame({1'b0, 15'h0014, 24'ha5403c, 5'h16, 3'h0}, 45, got);
    check("writes", wq.size(), 3);
    for (int k = 0; k < 3; k++) check("wr", wq[k], exp_w[k]);
    check("sync set", sync_hold_out, 1);
    wq.delete();
    host.frame({1'b0, 15'h0015, 32'h0}, 24, got);
    check("sync clear", sync_hold_out, 0);
    host.frame({1'b1, 15'h0123, 32'h0}, 32, got);
    check("rd3", got[15:0], {8'h23 ^ 8'h5a, 8'h24 ^ 8'h5a});
    check("no wr", wq.size(), 1);
    three_wire_disable_in = 1'b1;
    sdo_open_drain_in = 1'b1;
    host.frame({1'b1, 15'h7fff, 32'h0}, 24, got);
    check("rd4", got[7:0], 8'hff ^ 8'h5a);
    check("trig", n_trig, 4);
    power_down_n_in = 1'b0;
    wait_cyc(10);
    power_down_n_in = 1'b1;
    wait_cyc(10);
    check("short pd", {device_down_out, n_por[1:0]}, 3'h1);
    power_down_n_in = 1'b0;
    iface_strap_in = 1'b0;
    rom_page_strap_in = 2'h1;
    wait_cyc(40);
    check("down", device_down_out, 1);
    host.frame({1'b0, 15'h0015, 8'h40, 24'h0}, 24, got);
    check("quiet", wq.size(), 1);
    power_down_n_in = 1'b1;
    wait_cyc(10);
    check("por2", {device_down_out, n_por[1:0]}, 3'h2);
    check("i2c", {i2c_mode_out, rom_page_out, i2c_dev_addr_out}, {1'b1, 2'h1, 5'h0c, 2'h1});
    // i2c block write from 0x0030, then pointer to 0x0040 and a two-byte block read
    three_wire_disable_in = 1'b0;
    wq.delete();
    host.i2c_edge(1'b0);
    for (int k = 0; k < 8; k++) begin
      if (k == 5) begin
        host.i2c_edge(1'b1);
        check("i2c writes", wq.size(), 2);
        host.i2c_edge(1'b0);
      end
      host.i2c_byte({i2c_w[k], 1'b1}, ack);
      check("i2c ack", ack[0], 0);
    end
    host.i2c_edge(1'b0);
    host.i2c_byte({8'h63, 1'b1}, ack);
    check("i2c rd ack", ack[0], 0);
    host.i2c_byte(9'h1fe, ack);
    check("i2c rd0", ack[8:1], 8'h40 ^ 8'h5a);
    host.i2c_byte(9'h1ff, ack);
    check("i2c rd1", ack[8:1], 8'h41 ^ 8'h5a);
    host.i2c_edge(1'b1);
    check("i2c wr count", wq.size(), 2);
    check("i2c wr0", wq[0], {15'h0030, 8'h11});
    check("i2c wr1", wq[1], {15'h0031, 8'h22});
    close_out();
  end
endmodule
`default_nettype wire
